// *** sst_client_pkg.sv ***
// shared constants, types and the frame check function of the sensor client
package sst_client_pkg;

  // fixed bus addresses picked by the three-state strap
  localparam logic [7:0]  ADDR_GROUND      = 8'h48;
  localparam logic [7:0]  ADDR_FLOAT       = 8'h49;
  localparam logic [7:0]  ADDR_SUPPLY      = 8'h4a;
  localparam logic [1:0]  STRAP_GROUND     = 2'h0;
  localparam logic [1:0]  STRAP_FLOAT      = 2'h1;
  localparam logic [1:0]  STRAP_SUPPLY     = 2'h2;

  // frame check: crc-8, x^8 + x^2 + x + 1
  localparam logic [7:0]  CRC_INIT         = 8'h00;
  localparam logic [7:0]  CRC_POLY         = 8'h07;

  // command codes
  localparam logic [7:0]  CMD_INT_TEMP     = 8'h00;
  localparam logic [7:0]  CMD_EXT_TEMP     = 8'h01;
  localparam logic [7:0]  CMD_VOLT_FIRST   = 8'h10;
  localparam logic [7:0]  CMD_VOLT_LAST    = 8'h14;
  localparam logic [7:0]  CMD_DIB          = 8'hf7;
  localparam logic [7:0]  DIB_BYTES        = 8'h10;

  // measurement channels: two temperatures then five voltages
  localparam logic [2:0]  CH_COUNT         = 3'h7;
  localparam logic [2:0]  CH_INT           = 3'h0;
  localparam logic [2:0]  CH_EXT           = 3'h1;
  localparam logic [2:0]  CH_VOLT0         = 3'h2;

  // sensor error words
  localparam logic [15:0] ERR_DIODE_OPEN   = 16'h8102;
  localparam logic [15:0] ERR_DIODE_SHORT  = 16'h8103;
  // -273.125 degC in eighths (-2185), lowest legal reading code
  localparam logic [12:0] TEMP_RAW_MIN     = 13'h1777;
  localparam logic [15:0] TEMP_WORD_MIN    = 16'hbbb8;
  localparam logic [15:0] RESET_WORD       = 16'h0000;

  // timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          MIN_BIT_NS       = 500;
  localparam int          MIN_BIT_CYCLES   = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          REFRESH_MS       = 200;
  localparam int          SLOT_MS          = 25;
  localparam int          SLOT_CYCLES_DEF  = SLOT_MS * (1000000 / CLK_PERIOD_NS);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_HDR   = 7'h02,
    ST_WDATA = 7'h04,
    ST_RFCS  = 7'h08,
    ST_RDATA = 7'h10,
    ST_TFCS  = 7'h20,
    ST_SKIP  = 7'h40
  } engine_state_type;

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_byte

endpackage : sst_client_pkg

// *** sst_sensor_client.sv ***
// sst sensor client: transaction engine, measurement sequencer, tx fifo and serializer
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sst_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire do_write = in_valid && in_ready;
  wire do_read  = out_valid && out_ready;

  // full at exactly DEPTH entries; the count is one bit wider than the pointers
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge mclk) begin
    if (do_write) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_write) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_read)  rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_write) - (AW+1)'(do_read);
    end
  end
endmodule : sst_tx_fifo

////////////////////////////////////////////////////////////////////////////////
module sst_sensor_client
  import sst_client_pkg::*;
#(
  parameter int           SLOT_CYCLES = SLOT_CYCLES_DEF,
  parameter int           FIFO_DEPTH  = 32,
  // device identifier block, byte 1 in bits 7:0; value is arbitrary
  parameter logic [127:0] DIB_VALUE   = 128'h0
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [1:0]  address_strap_pin,
  input  wire logic        rx_start,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic [15:0] negotiated_bit_cycles,
  output logic             sst_out,
  output logic             sst_oe,
  output logic             conv_request,
  output logic [2:0]       conv_channel,
  input  wire logic        conv_done,
  input  wire logic [12:0] conv_raw,
  input  wire logic        diode_open,
  input  wire logic        diode_short,
  output logic [7:0]       bus_address
);

  ////////////////////////////////////////////////////////////////////////////
  // strap: caught once after reset release, held until the next reset

  logic       strap_taken;
  wire  [7:0] strap_address = (address_strap_pin == STRAP_GROUND) ? ADDR_GROUND :
                              (address_strap_pin == STRAP_FLOAT)  ? ADDR_FLOAT  :
                                                                    ADDR_SUPPLY;

  always_ff @(posedge mclk) begin
    if (reset) begin
      strap_taken <= 1'b0;
      bus_address <= ADDR_GROUND;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      bus_address <= strap_address;
    end
  end

  addr_legal_a: assert property (@(posedge mclk) disable iff (reset)
    strap_taken |-> (bus_address >= ADDR_GROUND && bus_address <= ADDR_SUPPLY))
    else $error("bus address outside fixed range");
  strap_hold_a: assert property (@(posedge mclk) disable iff (reset)
    strap_taken |=> $stable(bus_address))
    else $error("bus address changed after strap capture");

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequencer and result holding registers

  logic [31:0] slot_count;
  logic [2:0]  seq_ch;
  logic [15:0] result [7];
  logic        pend_valid;
  logic [2:0]  pend_ch;
  logic [15:0] pend_word;
  logic        read_busy;

  wire         slot_end = (slot_count == 32'(SLOT_CYCLES - 1));
  wire  [12:0] temp_clamped = ($signed(conv_raw) < $signed(TEMP_RAW_MIN)) ? TEMP_RAW_MIN
                                                                        : conv_raw;
  wire  [15:0] temp_word  = {temp_clamped, 3'h0};
  wire  [15:0] ext_word   = diode_open  ? ERR_DIODE_OPEN  :
                            diode_short ? ERR_DIODE_SHORT : temp_word;
  wire  [15:0] volt_word  = {1'b0, conv_raw[11:0], 3'h0};
  wire  [15:0] conv_word  = (conv_channel == CH_INT) ? temp_word :
                            (conv_channel == CH_EXT) ? ext_word  : volt_word;
  wire         commit     = pend_valid && !read_busy;

  always_ff @(posedge mclk) begin
    if (reset) begin
      slot_count   <= '0;
      seq_ch       <= CH_INT;
      conv_request <= 1'b0;
      conv_channel <= CH_INT;
    end else begin
      slot_count   <= slot_end ? '0 : slot_count + 32'h1;
      conv_request <= slot_end;
      if (slot_end) begin
        conv_channel <= seq_ch;
        seq_ch       <= (seq_ch == CH_COUNT - 3'h1) ? CH_INT : seq_ch + 3'h1;
      end
    end
  end

  // a conversion that lands during a read waits here, so no reading is torn
  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_valid <= 1'b0;
      pend_ch    <= CH_INT;
      pend_word  <= RESET_WORD;
    end else if (conv_done) begin
      pend_valid <= 1'b1;
      pend_ch    <= conv_channel;
      pend_word  <= conv_word;
    end else if (commit) begin
      pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 7; i++) result[i] <= RESET_WORD;
    end else if (commit) begin
      result[pend_ch] <= pend_word;
    end
  end

  slot_gap_a: assert property (@(posedge mclk) disable iff (reset)
    conv_request |=> !conv_request [*8])
    else $error("conversion requests too close together");
  volt_format_a: assert property (@(posedge mclk) disable iff (reset)
    (commit && pend_ch >= CH_VOLT0) |=> (result[$past(pend_ch)][15] == 1'b0
                                          && result[$past(pend_ch)][2:0] == 3'h0))
    else $error("voltage word with sign or low bits set");
  temp_floor_a: assert property (@(posedge mclk) disable iff (reset)
    (conv_done && conv_channel == CH_INT) |=> ($signed(pend_word) >= $signed(TEMP_WORD_MIN)))
    else $error("temperature below absolute zero");

  ////////////////////////////////////////////////////////////////////////////
  // transaction engine

  engine_state_type state;
  engine_state_type next_state;
  logic [1:0]       hdr_idx;
  logic [7:0]       wlen;
  logic [7:0]       rlen;
  logic [7:0]       wcount;
  logic [7:0]       rcount;
  logic [7:0]       cmd;
  logic [7:0]       crc;
  logic [7:0]       push_data;
  logic             push_valid;
  logic             push_ready;

  wire        cmd_is_volt = (cmd >= CMD_VOLT_FIRST) && (cmd <= CMD_VOLT_LAST);
  wire        cmd_is_meas = (cmd == CMD_INT_TEMP) || (cmd == CMD_EXT_TEMP) || cmd_is_volt;
  wire  [7:0] base_ch     = cmd_is_volt ? (cmd - CMD_VOLT_FIRST + 8'(CH_VOLT0)) : cmd;
  wire  [7:0] word_ch     = base_ch + {1'b0, rcount[7:1]};
  wire        word_ok     = cmd_is_meas && (word_ch < 8'(CH_COUNT));
  wire  [15:0] read_word  = word_ok ? result[word_ch[2:0]] : RESET_WORD;
  wire  [7:0] meas_byte   = rcount[0] ? read_word[15:8] : read_word[7:0];
  wire  [7:0] dib_byte    = (rcount < DIB_BYTES) ? DIB_VALUE[{rcount[3:0], 3'h0} +: 8] : 8'h00;
  wire  [7:0] read_byte   = (cmd == CMD_DIB) ? dib_byte : meas_byte;
  wire  [7:0] rx_crc      = crc8_byte(crc, rx_byte);
  wire  [7:0] tx_crc      = crc8_byte(crc, push_data);
  wire        push_done   = push_valid && push_ready;

  assign read_busy  = (state == ST_RFCS) || (state == ST_RDATA);
  assign push_valid = (state == ST_RFCS) || (state == ST_RDATA) || (state == ST_TFCS);
  assign push_data  = (state == ST_RDATA) ? read_byte : crc;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE, ST_SKIP: next_state = state;
      ST_HDR: begin
        if (rx_valid && hdr_idx == 2'h0 && rx_byte != bus_address) next_state = ST_SKIP;
        if (rx_valid && hdr_idx == 2'h2) next_state = (wlen == 8'h0) ? ST_RFCS : ST_WDATA;
      end
      ST_WDATA: if (rx_valid && wcount == wlen - 8'h1) next_state = ST_RFCS;
      ST_RFCS:  if (push_done) next_state = (rlen == 8'h0) ? ST_IDLE : ST_RDATA;
      ST_RDATA: if (push_done && rcount == rlen - 8'h1) next_state = ST_TFCS;
      ST_TFCS:  if (push_done) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
    // a new message start always takes over; negotiation bits never reach here
    if (rx_start) next_state = ST_HDR;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hdr_idx <= 2'h0;
      wlen    <= 8'h0;
      rlen    <= 8'h0;
      wcount  <= 8'h0;
      rcount  <= 8'h0;
      cmd     <= 8'h0;
      crc     <= CRC_INIT;
    end else if (rx_start) begin
      hdr_idx <= 2'h0;
      wcount  <= 8'h0;
      rcount  <= 8'h0;
      crc     <= CRC_INIT;
    end else if (rx_valid && (state == ST_HDR || state == ST_WDATA)) begin
      crc <= rx_crc;
      if (state == ST_HDR) begin
        hdr_idx <= hdr_idx + 2'h1;
        if (hdr_idx == 2'h1) wlen <= rx_byte;
        if (hdr_idx == 2'h2) rlen <= rx_byte;
      end else begin
        if (wcount == 8'h0) cmd <= rx_byte;
        wcount <= wcount + 8'h1;
      end
    end else if (push_done) begin
      if (state == ST_RFCS) crc <= CRC_INIT;
      if (state == ST_RDATA) begin
        crc    <= tx_crc;
        rcount <= rcount + 8'h1;
      end
    end
  end

  crc_restart_a: assert property (@(posedge mclk) disable iff (reset)
    rx_start |=> (crc == CRC_INIT && state == ST_HDR))
    else $error("frame check not restarted at message start");
  fcs_after_a: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_RDATA && push_done && rcount == rlen - 8'h1 && !rx_start)
      |=> (state == ST_TFCS && push_data == crc))
    else $error("second check byte does not follow read data");
  fcs_first_a: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_WDATA && rx_valid && wcount == wlen - 8'h1 && !rx_start)
      |=> (state == ST_RFCS && push_valid))
    else $error("check byte not returned after write data");
  atomic_read_a: assert property (@(posedge mclk) disable iff (reset)
    (state == ST_RDATA && push_done && !rcount[0] && !rx_start) |=> $stable(read_word))
    else $error("reading changed between its low and high byte");

  ////////////////////////////////////////////////////////////////////////////
  // tx buffer and bit serializer

  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] shreg;
  logic [3:0] bits_left;
  logic [15:0] bit_timer;
  logic [15:0] bit_period;

  // slower negotiated rates are followed; faster than 2 Mbps is clamped
  wire [15:0] period_pick = (negotiated_bit_cycles < 16'(MIN_BIT_CYCLES)) ?
                            16'(MIN_BIT_CYCLES) : negotiated_bit_cycles;
  wire        bit_end     = (bit_timer == bit_period - 16'h1);

  assign fifo_out_ready = (bits_left == 4'h0);

  sst_tx_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // client drives the line only while its own bit is on the wire
  always_ff @(posedge mclk) begin
    if (reset) begin
      shreg      <= 8'h0;
      bits_left  <= 4'h0;
      bit_timer  <= 16'h0;
      bit_period <= 16'(MIN_BIT_CYCLES);
      sst_out    <= 1'b0;
      sst_oe     <= 1'b0;
    end else if (bits_left == 4'h0) begin
      sst_oe <= 1'b0;
      if (fifo_out_valid) begin
        shreg      <= {fifo_out_data[6:0], 1'b0};
        sst_out    <= fifo_out_data[7];
        sst_oe     <= 1'b1;
        bits_left  <= 4'h8;
        bit_timer  <= 16'h0;
        bit_period <= period_pick;
      end
    end else if (bit_end) begin
      bit_timer <= 16'h0;
      bits_left <= bits_left - 4'h1;
      sst_out   <= shreg[7];
      shreg     <= {shreg[6:0], 1'b0};
      sst_oe    <= (bits_left != 4'h1);
    end else begin
      bit_timer <= bit_timer + 16'h1;
    end
  end

  bit_rate_a: assert property (@(posedge mclk) disable iff (reset)
    (bits_left != 4'h0) |-> (bit_period >= 16'(MIN_BIT_CYCLES) && sst_oe))
    else $error("bit period faster than 2 Mbps");

endmodule : sst_sensor_client

// *** sst_host_model.sv ***
// host controller model: sends message bytes and collects the serialized reply bytes
`timescale 1ns/1ps

module sst_host_model (
  input  wire logic        mclk,
  input  wire logic        sst_out,
  input  wire logic        sst_oe,
  input  wire logic [15:0] bit_cycles,
  output logic             rx_start,
  output logic             rx_valid,
  output logic [7:0]       rx_byte
);
  logic [7:0] got [$];
  logic [7:0] shreg;
  int         cnt;

  initial begin
    rx_start = 1'b0;
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    shreg    = 8'h00;
    cnt      = 0;
  end

  // the client clamps short bit times, so the sampling point must follow the same clamp
  function automatic int per();
    return (bit_cycles < 16'd50) ? 50 : int'(bit_cycles);
  endfunction : per

  ////////////////////////////////////////////////////////////
  // negotiation bits are handled outside; address byte comes first after start
  task automatic send_msg(input logic [7:0] msg [$]);
    @(posedge mclk);
    #1 rx_start = 1'b1;
    foreach (msg[i]) begin
      @(posedge mclk);
      #1 rx_start = 1'b0;
      rx_valid = 1'b1;
      rx_byte  = msg[i];
    end
    @(posedge mclk);
    #1 rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask : send_msg

  // sample each bit mid-period; the line is only meaningful while driven
  always @(posedge mclk) begin
    if (!sst_oe) begin
      cnt = 0;
    end else begin
      if (cnt % per() == per() / 2) begin
        shreg = {shreg[6:0], sst_out};
        if (cnt / per() == 7) got.push_back(shreg);
      end
      cnt++;
    end
  end
endmodule : sst_host_model

// *** sst_sensor_client_test.sv ***
// self-checking bench of the sensor client with host and converter models
`timescale 1ns/1ps

`define CHK(nm, ex, sn) begin tests_run++; if ((sn) !== (ex)) begin $display("BAD %s expected %h seen %h", nm, ex, sn); err_count++; end end

module sst_sensor_client_test;
  import sst_client_pkg::*;
  localparam int           SLOT = 20;
  // identifier block contents are arbitrary
  localparam logic [127:0] DIB  = 128'h0123456789abcdef0fedcba987654321;

  logic        mclk, reset, rx_start, rx_valid, sst_out, sst_oe;
  logic        conv_request, conv_done, diode_open, diode_short;
  logic [1:0]  address_strap_pin;
  logic [2:0]  conv_channel;
  logic [7:0]  rx_byte, bus_address;
  logic [12:0] conv_raw;
  logic [15:0] bits;
  logic [12:0] raw_tab [7];
  logic [7:0]  cmds [10] = '{8'h00, 8'h01, 8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'hf7, 8'h02};
  int          lens [10] = '{2, 2, 4, 10, 2, 2, 2, 2, 16, 2};
  int          err_count, tests_run, last_ch, gap;
  integer      seed;

  sst_sensor_client #(.SLOT_CYCLES(SLOT), .FIFO_DEPTH(32), .DIB_VALUE(DIB)) u_dut (
    .mclk(mclk), .reset(reset), .address_strap_pin(address_strap_pin),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .negotiated_bit_cycles(bits), .sst_out(sst_out), .sst_oe(sst_oe),
    .conv_request(conv_request), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_raw(conv_raw), .diode_open(diode_open), .diode_short(diode_short),
    .bus_address(bus_address));

  sst_host_model u_host (
    .mclk(mclk), .sst_out(sst_out), .sst_oe(sst_oe), .bit_cycles(bits),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    c ^= d;
    repeat (8) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction : crc

  function automatic logic [15:0] exp_word(input int ch);
    logic signed [12:0] r;
    r = raw_tab[ch];
    if (ch == 1 && diode_open) return 16'h8102;
    if (ch == 1 && diode_short) return 16'h8103;
    if (ch > 1) return {1'b0, r[11:0], 3'h0};
    if (r < -13'sd2185) r = -13'sd2185;
    return {r, 3'h0};
  endfunction : exp_word

  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // converter model answers a few cycles after each request, well inside one slot
  always @(posedge mclk) if (conv_request) begin
    automatic int ch = conv_channel;
    repeat (1 + {$random(seed)} % 6) @(posedge mclk);
    #1 conv_done = 1'b1;
    conv_raw = raw_tab[ch];
    @(posedge mclk);
    #1 conv_done = 1'b0;
    conv_raw = ~conv_raw;
  end

  always @(posedge mclk) begin
    if (reset) begin
      last_ch = 6;
      gap = -1;
    end else begin
      if (gap >= 0) gap++;
      if (conv_request) begin
        `CHK("conv_channel", 3'((last_ch + 1) % 7), conv_channel)
        if (gap > 0) `CHK("conv_gap", SLOT, gap)
        last_ch = conv_channel;
        gap = 0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic read_cmd(input logic [7:0] addr, input logic [7:0] cmd, input int len,
                          input bit atom);
    logic [7:0]  msg [$];
    logic [7:0]  c;
    logic [15:0] w, e, alt;
    int          ch, n, exp_n;
    msg = '{addr, 8'h01, 8'(len), cmd};
    exp_n = (addr == 8'h4a) ? len + 2 : 0;
    alt = exp_word(0);
    c = 8'h00;
    u_host.got.delete();
    u_host.send_msg(msg);
    // the old reading may still be in flight while a fresh conversion lands
    if (atom) raw_tab[0] = 13'($random(seed));
    for (n = 0; n < ((exp_n == 0) ? 2000 : 30000) && (exp_n == 0 || u_host.got.size() < exp_n);
         n++) @(posedge mclk);
    `CHK("reply_len", exp_n, u_host.got.size())
    if (u_host.got.size() != exp_n) end_of_test();
    if (exp_n == 0) return;
    foreach (msg[i]) c = crc(c, msg[i]);
    `CHK("fcs_hdr", c, u_host.got[0])
    for (int k = 0; k < len / 2; k++) begin
      w = {u_host.got[2 + 2 * k], u_host.got[1 + 2 * k]};
      ch = (cmd <= 8'h01) ? int'(cmd) + k : (cmd >= 8'h10 && cmd <= 8'h14) ? int'(cmd) - 14 + k : 99;
      e = (cmd == 8'hf7) ? DIB[16 * k +: 16] : (ch > ((cmd <= 8'h01) ? 1 : 6)) ? 16'h0000 : exp_word(ch);
      if (atom && w === alt) e = alt;
      `CHK("reading", e, w)
    end
    c = 8'h00;
    for (int i = 1; i <= len; i++) c = crc(c, u_host.got[i]);
    `CHK("fcs_data", c, u_host.got[len + 1])
  endtask : read_cmd

  initial begin
    seed = 32'hc3236db9;
    reset = 1'b1;
    address_strap_pin = 2'h0;
    bits = 16'd50;
    conv_done = 1'b0;
    conv_raw = 13'h0000;
    diode_open = 1'b0;
    diode_short = 1'b0;
    err_count = 0;
    tests_run = 0;
    foreach (raw_tab[i]) raw_tab[i] = 13'h0000;
    for (int s = 0; s < 4; s++) begin
      @(posedge mclk);
      #1 reset = 1'b1;
      address_strap_pin = 2'(s);
      repeat (2) @(posedge mclk);
      #1 reset = 1'b0;
      repeat (2) @(posedge mclk);
      #1 address_strap_pin = 2'(s + 1);
      repeat (3) @(posedge mclk);
      `CHK("bus_address", 8'h48 + 8'((s > 2) ? 2 : s), bus_address)
    end
    for (int it = 0; it < 20; it++) begin
      @(posedge mclk);
      // a bit time of 10 cycles checks the clamp to the fastest rate
      #1 bits = (it == 0) ? 16'd10 : 16'(50 + {$random(seed)} % 40);
      diode_open = (it == 1 || it == 12);
      diode_short = (it == 11 || it == 12);
      for (int i = 0; i < 7; i++) raw_tab[i] = (i < 2) ? 13'($random(seed)) : {1'b0, 12'($random(seed))};
      if (it == 0) raw_tab[0] = 13'h1000;
      if (it == 2) raw_tab[0] = 13'h1776;
      if (it == 5) raw_tab[0] = 13'h1777;
      if (it == 3) raw_tab[2] = 13'h0fff;
      repeat (2 * 7 * SLOT + 40) @(posedge mclk);
      read_cmd(8'h4a, cmds[it % 10], lens[it % 10], it == 10);
      if (it == 14) read_cmd(8'h48, 8'h00, 2, 1'b0);
    end
    end_of_test();
  end
endmodule : sst_sensor_client_test
